// File: logic/imc_defs.vh
// Constants for the interrupt mask and command register block
`ifndef IMC_DEFS_VH
`define IMC_DEFS_VH

`define IMC_ADDR_W          12
`define IMC_DATA_W          32

`define IMC_OFS_CUR_VEC     12'h100
`define IMC_OFS_FAST_VEC    12'h104
`define IMC_OFS_CUR_ID      12'h108
`define IMC_OFS_PENDING     12'h10C
`define IMC_OFS_MASK        12'h110
`define IMC_OFS_LINE_STAT   12'h114
`define IMC_OFS_EN_CMD      12'h120
`define IMC_OFS_DIS_CMD     12'h124
`define IMC_OFS_CLR_CMD     12'h128
`define IMC_OFS_SET_CMD     12'h12C
`define IMC_OFS_EOS_CMD     12'h130
`define IMC_OFS_SPUR_VEC    12'h134
`define IMC_OFS_DEBUG       12'h138
`define IMC_OFS_FF_EN       12'h140
`define IMC_OFS_FF_DIS      12'h144
`define IMC_OFS_FF_STAT     12'h148
`define IMC_OFS_EVT_STAT    12'h150
`define IMC_OFS_EVT_MASK    12'h154

`define IMC_BIT_FAST_LINE   0
`define IMC_BIT_NORM_LINE   1
`define IMC_BIT_GUARD       0
`define IMC_BIT_GATE        1

`define IMC_EVT_W           4
`define IMC_EVT_NORM_RISE   0
`define IMC_EVT_FAST_RISE   1
`define IMC_EVT_EOS         2
`define IMC_EVT_SPUR        3

`define IMC_RST_MASK        32'h00000000
`define IMC_RST_SPUR        32'h00000000
`define IMC_RST_DEBUG       2'h0
`define IMC_FF_IMPL         32'hFFFFFFFE

`endif

// File: logic/imc_top.v
// Interrupt mask, pending command, vector readout and core line control
`include "imc_defs.vh"

module imc_top #(
    parameter NSRC = 32
) (
    input  wire                   clk_i,
    input  wire                   nrst_i,
    input  wire                   ce_i,
    input  wire [11:0]            addr_i,
    input  wire [31:0]            wdata_i,
    input  wire                   wr_i,
    input  wire                   rd_i,
    output wire [31:0]            rdata_o,
    input  wire [31:0]            src_i,
    output wire [4:0]             vec_idx_o,
    input  wire [31:0]            vec_data_i,
    input  wire [31:0]            fast_vec_i,
    output wire                   fast_interrupt_line_n_o,
    output wire                   normal_interrupt_line_n_o,
    output wire                   irq_o
);

    // Source sampling, two stages before any logic
    reg  [31:0] src_meta_q;
    reg  [31:0] src_sync_q;
    reg  [31:0] src_prev_q;

    // Programmable state
    reg  [31:0] mask_q;
    reg  [31:0] pend_q;
    reg  [31:0] ffs_q;
    reg  [31:0] spur_q;
    reg  [1:0]  dbg_q;
    reg         busy_q;
    reg  [4:0]  cur_id_q;
    reg         fast_act_q;
    reg         norm_act_q;
    reg  [`IMC_EVT_W-1:0] evt_q;
    reg  [`IMC_EVT_W-1:0] emask_q;
    reg  [31:0] rdata_q;

    reg  [31:0] mask_d;
    reg  [31:0] pend_d;
    reg  [31:0] ffs_d;
    reg  [1:0]  dbg_d;
    reg         busy_d;
    reg  [4:0]  cur_id_d;
    reg  [`IMC_EVT_W-1:0] evt_d;
    reg  [`IMC_EVT_W-1:0] evt_set;
    reg  [31:0] rdata_d;

    // Lowest numbered normal source wins; bit 5 flags a hit
    function [5:0] imc_first;
        input [31:0] v;
        integer k;
        begin
            imc_first = 6'h00;
            for (k = 31; k >= 1; k = k - 1)
            begin
                if (v[k])
                begin
                    imc_first = {1'b1, k[4:0]};
                end
            end
        end
    endfunction

    // Strobe decoding
    wire wr_en    = wr_i && (addr_i == `IMC_OFS_EN_CMD);
    wire wr_dis   = wr_i && (addr_i == `IMC_OFS_DIS_CMD);
    wire wr_clr   = wr_i && (addr_i == `IMC_OFS_CLR_CMD);
    wire wr_set   = wr_i && (addr_i == `IMC_OFS_SET_CMD);
    wire wr_eos   = wr_i && (addr_i == `IMC_OFS_EOS_CMD);
    wire wr_spur  = wr_i && (addr_i == `IMC_OFS_SPUR_VEC);
    wire wr_dbg   = wr_i && (addr_i == `IMC_OFS_DEBUG);
    wire wr_ffe   = wr_i && (addr_i == `IMC_OFS_FF_EN);
    wire wr_ffd   = wr_i && (addr_i == `IMC_OFS_FF_DIS);
    wire wr_evt   = wr_i && (addr_i == `IMC_OFS_EVT_STAT);
    wire wr_emask = wr_i && (addr_i == `IMC_OFS_EVT_MASK);
    wire rd_cvec  = rd_i && (addr_i == `IMC_OFS_CUR_VEC);
    wire wr_cvec  = wr_i && (addr_i == `IMC_OFS_CUR_VEC);
    wire rd_fvec  = rd_i && (addr_i == `IMC_OFS_FAST_VEC);

    wire guard = dbg_q[`IMC_BIT_GUARD];
    wire gate  = dbg_q[`IMC_BIT_GATE];

    // Acknowledge by read, or by write while guarded
    wire ack_cvec = guard ? wr_cvec : rd_cvec;

    // New source edges set pending
    wire [31:0] src_edge = src_sync_q & ~src_prev_q;

    // Normal candidates exclude forced sources and the fast source
    wire [31:0] norm_cand = pend_q & mask_q & ~ffs_q & 32'hFFFFFFFE;
    wire [31:0] fast_cand = pend_q & mask_q & (ffs_q | 32'h00000001);
    wire [5:0]  pick      = imc_first(norm_cand);
    wire        norm_hit  = pick[5];
    wire        fast_hit  = |fast_cand;

    // Vector table lookup index
    assign vec_idx_o = busy_q ? cur_id_q : pick[4:0];

    // Line requests after the general gate
    wire fast_req = fast_hit && !gate;
    wire norm_req = norm_hit && !busy_q && !gate;

    always @*
    begin
        mask_d = mask_q;
        if (wr_en)
        begin
            mask_d = mask_d | wdata_i;
        end
        if (wr_dis)
        begin
            mask_d = mask_d & ~wdata_i;
        end
    end

    always @*
    begin
        ffs_d = ffs_q;
        if (wr_ffe)
        begin
            ffs_d = ffs_d | (wdata_i & `IMC_FF_IMPL);
        end
        if (wr_ffd)
        begin
            ffs_d = ffs_d & ~(wdata_i & `IMC_FF_IMPL);
        end
    end

    always @*
    begin
        pend_d = pend_q;
        if (wr_clr)
        begin
            pend_d = pend_d & ~wdata_i;
        end
        if (ack_cvec && norm_hit && !busy_q)
        begin
            pend_d[pick[4:0]] = 1'b0;
        end
        if (rd_fvec)
        begin
            pend_d = pend_d & ~fast_cand;
        end
        // Set wins over any clear in the same cycle
        pend_d = pend_d | src_edge;
        if (wr_set)
        begin
            pend_d = pend_d | wdata_i;
        end
    end

    always @*
    begin
        busy_d   = busy_q;
        cur_id_d = cur_id_q;
        if (wr_eos)
        begin
            busy_d = 1'b0;
        end
        if (ack_cvec && norm_hit && !busy_q)
        begin
            busy_d   = 1'b1;
            cur_id_d = pick[4:0];
        end
    end

    always @*
    begin
        dbg_d = dbg_q;
        if (wr_dbg)
        begin
            dbg_d = wdata_i[1:0];
        end
    end

    always @*
    begin
        evt_set = {`IMC_EVT_W{1'b0}};
        evt_set[`IMC_EVT_NORM_RISE] = norm_req && !norm_act_q;
        evt_set[`IMC_EVT_FAST_RISE] = fast_req && !fast_act_q;
        evt_set[`IMC_EVT_EOS]       = wr_eos;
        evt_set[`IMC_EVT_SPUR]      = (ack_cvec && !(norm_hit && !busy_q) && !busy_q)
                                    || (rd_fvec && !fast_hit);
        evt_d = evt_q;
        if (wr_evt)
        begin
            evt_d = evt_d & ~wdata_i[`IMC_EVT_W-1:0];
        end
        evt_d = evt_d | evt_set;
    end

    // Read mux, unmapped reads give zero
    always @*
    begin
        rdata_d = 32'h00000000;
        if (!rd_i)
        begin
            rdata_d = 32'h00000000;
        end
        else if (addr_i == `IMC_OFS_CUR_VEC)
        begin
            if (busy_q || norm_hit)
            begin
                rdata_d = vec_data_i;
            end
            else
            begin
                rdata_d = spur_q;
            end
        end
        else if (addr_i == `IMC_OFS_FAST_VEC)
        begin
            rdata_d = fast_hit ? fast_vec_i : spur_q;
        end
        else if (addr_i == `IMC_OFS_CUR_ID)
        begin
            rdata_d = {27'h0000000, cur_id_q};
        end
        else if (addr_i == `IMC_OFS_PENDING)
        begin
            rdata_d = pend_q;
        end
        else if (addr_i == `IMC_OFS_MASK)
        begin
            rdata_d = mask_q;
        end
        else if (addr_i == `IMC_OFS_LINE_STAT)
        begin
            rdata_d = {30'h00000000, norm_act_q, fast_act_q};
        end
        else if (addr_i == `IMC_OFS_SPUR_VEC)
        begin
            rdata_d = spur_q;
        end
        else if (addr_i == `IMC_OFS_DEBUG)
        begin
            rdata_d = {30'h00000000, dbg_q};
        end
        else if (addr_i == `IMC_OFS_FF_STAT)
        begin
            rdata_d = ffs_q;
        end
        else if (addr_i == `IMC_OFS_EVT_STAT)
        begin
            rdata_d = {28'h0000000, evt_q};
        end
        else if (addr_i == `IMC_OFS_EVT_MASK)
        begin
            rdata_d = {28'h0000000, emask_q};
        end
        else
        begin
            rdata_d = 32'h00000000;
        end
    end

    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            src_meta_q <= 32'h00000000;
            src_sync_q <= 32'h00000000;
            src_prev_q <= 32'h00000000;
            mask_q     <= `IMC_RST_MASK;
            pend_q     <= 32'h00000000;
            ffs_q      <= 32'h00000000;
            spur_q     <= `IMC_RST_SPUR;
            dbg_q      <= `IMC_RST_DEBUG;
            busy_q     <= 1'b0;
            cur_id_q   <= 5'h00;
            fast_act_q <= 1'b0;
            norm_act_q <= 1'b0;
            evt_q      <= {`IMC_EVT_W{1'b0}};
            emask_q    <= {`IMC_EVT_W{1'b0}};
            rdata_q    <= 32'h00000000;
        end
        else if (ce_i)
        begin
            src_meta_q <= src_i;
            src_sync_q <= src_meta_q;
            src_prev_q <= src_sync_q;
            mask_q     <= mask_d;
            pend_q     <= pend_d;
            ffs_q      <= ffs_d;
            if (wr_spur)
            begin
                spur_q <= wdata_i;
            end
            dbg_q      <= dbg_d;
            busy_q     <= busy_d;
            cur_id_q   <= cur_id_d;
            fast_act_q <= fast_req;
            norm_act_q <= norm_req;
            evt_q      <= evt_d;
            if (wr_emask)
            begin
                emask_q <= wdata_i[`IMC_EVT_W-1:0];
            end
            rdata_q    <= rdata_d;
        end
    end

    assign rdata_o                   = rdata_q;
    assign fast_interrupt_line_n_o   = ~fast_act_q;
    assign normal_interrupt_line_n_o = ~norm_act_q;
    assign irq_o                     = |(evt_q & emask_q);

endmodule

// File: tb/imc_checker.sv
// Concurrent checks on the register and core line ports
module imc_checker #(
    parameter NSRC = 32
) (
    input wire        clk_i,
    input wire        nrst_i,
    input wire        ce_i,
    input wire [11:0] addr_i,
    input wire [31:0] wdata_i,
    input wire        wr_i,
    input wire        rd_i,
    input wire [31:0] rdata_o,
    input wire [31:0] src_i,
    input wire [4:0]  vec_idx_o,
    input wire [31:0] vec_data_i,
    input wire [31:0] fast_vec_i,
    input wire        fast_interrupt_line_n_o,
    input wire        normal_interrupt_line_n_o,
    input wire        irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    wire w = wr_i && ce_i;
    wire r = rd_i && ce_i;
    // Write one place, read the same or another on the very next cycle
    sequence wr_rd(wa, ra);
        w && addr_i == wa ##1 r && addr_i == ra;
    endsequence
    en_set_a: assert property (wr_rd(12'h120, 12'h110) |=>
        (rdata_o & $past(wdata_i, 2)) == $past(wdata_i, 2)) else $error("mask not set");
    dis_clr_a: assert property (wr_rd(12'h124, 12'h110) |=>
        (rdata_o & $past(wdata_i, 2)) == 0) else $error("mask not cleared");
    spur_rw_a: assert property (wr_rd(12'h134, 12'h134) |=>
        rdata_o == $past(wdata_i, 2)) else $error("spurious address lost");
    ff_set_a: assert property (wr_rd(12'h140, 12'h148) |=>
        (rdata_o & ($past(wdata_i, 2) | 32'h1)) == ($past(wdata_i, 2) & 32'hFFFFFFFE))
        else $error("forcing not set");
    ff_clr_a: assert property (wr_rd(12'h144, 12'h148) |=>
        (rdata_o & $past(wdata_i, 2)) == 0) else $error("forcing not cleared");
    gate_hold_a: assert property (w && addr_i == 12'h138 && wdata_i[1] ##1 ce_i |=>
        fast_interrupt_line_n_o && normal_interrupt_line_n_o) else $error("gated line active");
    fast_stat_a: assert property (r && addr_i == 12'h114 |=>
        rdata_o[0] != $past(fast_interrupt_line_n_o)) else $error("fast status wrong");
    norm_stat_a: assert property (r && addr_i == 12'h114 |=>
        rdata_o[1] != $past(normal_interrupt_line_n_o)) else $error("normal status wrong");
    cover property (!normal_interrupt_line_n_o);
    cover property (!fast_interrupt_line_n_o);
    cover property (irq_o);
endmodule

bind imc_top imc_checker #(.NSRC(NSRC)) chk_u (.clk_i, .nrst_i, .ce_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .src_i, .vec_idx_o, .vec_data_i, .fast_vec_i,
    .fast_interrupt_line_n_o, .normal_interrupt_line_n_o, .irq_o);

// File: tb/imc_core_model.sv
// Handler table and fast vector on the far side of the controller
module imc_core_model (
    input  wire [4:0]  vec_idx_i,
    output wire [31:0] vec_data_o,
    output wire [31:0] fast_vec_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Handler address encodes the source index
    assign vec_data_o = {20'h00008, 5'h00, vec_idx_i, 2'h0};
    assign fast_vec_o = 32'h00007F00;
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the interrupt mask and command block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [11:0] wa;
        logic [31:0] wd;
        logic [11:0] ra;
        logic [31:0] ex;
    } imc_row_t;
    logic        clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        ce_i = 1'b1;
    logic [11:0] addr_i = 12'h000;
    logic [31:0] wdata_i = 32'h00000000;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [31:0] src_i = 32'h00000000;
    wire  [31:0] rdata_o;
    wire  [4:0]  vec_idx_o;
    wire  [31:0] vec_data_i;
    wire  [31:0] fast_vec_i;
    wire         fast_n;
    wire         norm_n;
    wire         irq_o;
    logic [31:0] d;
    logic        i0;
    int          errors = 0;
    int          comparisons = 0;
    int          cycles = 0;
    imc_row_t    rows [0:12] = '{
        '{12'hFFC, 32'h0, 12'h110, 32'h0}, '{12'hFFC, 32'h0, 12'h134, 32'h0},
        '{12'hFFC, 32'h0, 12'h138, 32'h0}, '{12'h134, 32'h5A5A0134, 12'h134, 32'h5A5A0134},
        '{12'h120, 32'hF00000F6, 12'h110, 32'hF00000F6},
        '{12'h124, 32'h90000006, 12'h110, 32'h600000F0},
        '{12'h110, 32'hFFFFFFFF, 12'h110, 32'h600000F0},
        '{12'h140, 32'hFFFFFFFF, 12'h148, 32'hFFFFFFFE},
        '{12'h144, 32'hFFFFFF00, 12'h148, 32'h000000FE},
        '{12'h144, 32'h000000FF, 12'h148, 32'h0}, '{12'h138, 32'h1, 12'h138, 32'h1},
        '{12'h138, 32'h0, 12'h138, 32'h0}, '{12'h124, 32'hFFFFFFFF, 12'h110, 32'h0}};

    imc_top dut_u (.clk_i, .nrst_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .src_i, .vec_idx_o, .vec_data_i, .fast_vec_i, .fast_interrupt_line_n_o(fast_n),
        .normal_interrupt_line_n_o(norm_n), .irq_o);
    imc_core_model core_u (.vec_idx_i(vec_idx_o), .vec_data_o(vec_data_i),
        .fast_vec_o(fast_vec_i));

    initial
        forever #2 clk_i = ~clk_i;

    task automatic print_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Write, then read on the next cycle; FFC is an unmapped filler
    task automatic bus(input logic [11:0] wa, input logic [31:0] wd,
                       input logic [11:0] ra, output logic [31:0] q);
        @(posedge clk_i);
        addr_i <= wa;
        wdata_i <= wd;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        addr_i <= ra;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 q = rdata_o;
    endtask

    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            errors++;
            print_verdict();
        end
    end

    initial
    begin
        repeat (6) @(posedge clk_i);
        nrst_i <= 1'b1;
        foreach (rows[k])
        begin
            bus(rows[k].wa, rows[k].wd, rows[k].ra, d);
            chk(d, rows[k].ex);
        end
        bus(12'h120, 32'h6, 12'hFFC, d);
        bus(12'h12C, 32'h6, 12'h10C, d);
        chk(d, 32'h6);
        bus(12'hFFC, 32'h0, 12'h114, d);
        chk(d, 32'h2);
        bus(12'hFFC, 32'h0, 12'h100, d);
        chk(d, 32'h8004);
        bus(12'h130, 32'hA5A5, 12'h100, d);
        chk(d, 32'h8008);
        bus(12'h130, 32'h0, 12'h10C, d);
        chk(d, 32'h0);
        bus(12'h12C, 32'h30, 12'hFFC, d);
        bus(12'h128, 32'h10, 12'h10C, d);
        chk(d, 32'h20);
        bus(12'h128, 32'h20, 12'h100, d);
        chk(d, 32'h5A5A0134);
        bus(12'h138, 32'h2, 12'hFFC, d);
        bus(12'h12C, 32'h2, 12'hFFC, d);
        chk({30'h0, norm_n, fast_n}, 32'h3);
        bus(12'h138, 32'h1, 12'hFFC, d);
        chk({30'h0, norm_n, fast_n}, 32'h1);
        bus(12'hFFC, 32'h0, 12'h100, d);
        bus(12'hFFC, 32'h0, 12'h10C, d);
        chk(d, 32'h2);
        bus(12'h100, 32'h0, 12'h10C, d);
        chk(d, 32'h0);
        bus(12'h130, 32'h0, 12'h138, d);
        chk(d, 32'h1);
        bus(12'h138, 32'h0, 12'hFFC, d);
        bus(12'h120, 32'h9, 12'hFFC, d);
        bus(12'h140, 32'h8, 12'hFFC, d);
        @(posedge clk_i);
        src_i <= 32'h1;
        repeat (5) @(posedge clk_i);
        #1 chk({30'h0, norm_n, fast_n}, 32'h2);
        bus(12'hFFC, 32'h0, 12'h104, d);
        chk(d, 32'h7F00);
        bus(12'h12C, 32'h8, 12'h114, d);
        chk(d, 32'h0);
        bus(12'hFFC, 32'h0, 12'h114, d);
        chk(d, 32'h1);
        bus(12'hFFC, 32'h0, 12'h104, d);
        bus(12'hFFC, 32'h0, 12'h104, d);
        chk(d, 32'h5A5A0134);
        bus(12'h154, 32'h0, 12'h150, d);
        chk(d, 32'hF);
        i0 = irq_o;
        bus(12'h154, 32'hF, 12'hFFC, d);
        chk({31'h0, i0 ^ irq_o}, 32'h1);
        bus(12'h150, 32'hF, 12'h150, d);
        chk(d | {31'h0, irq_o}, 32'h0);
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        bus(12'hFFC, 32'h0, 12'h110, d);
        chk(d, 32'h0);
        bus(12'hFFC, 32'h0, 12'h148, d);
        chk(d, 32'h0);
        print_verdict();
    end
endmodule
